// ---- rtl/ccr_pkg.sv ----
// Shared constants and types of the configuration register bank.
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register offsets and sizes
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 8;
  localparam int          CHANNELS     = 8;
  localparam logic [7:0]  ADDR_CSUM_LO = 8'h23;
  localparam logic [7:0]  ADDR_CSUM_HI = 8'h24;
  localparam logic [7:0]  ADDR_DEVCTL  = 8'h25;
  localparam logic [7:0]  ADDR_PKTFMT  = 8'h26;
  localparam logic [7:0]  ADDR_IRQ_STS = 8'hc0;
  localparam logic [7:0]  ADDR_IRQ_MSK = 8'hc1;
  localparam logic [7:0]  SCAN_FIRST   = 8'hb9;
  localparam logic [7:0]  SCAN_LAST    = 8'h25;

  // ----------------------------------------------------------------
  // Reset values, field positions and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CSUM_RST     = 16'h0000;
  localparam logic [7:0]  DEVCTL_RST   = 8'h11;
  localparam logic [7:0]  PKTFMT_RST   = 8'h01;
  localparam logic [7:0]  DEVCTL_MASK  = 8'h9f;
  localparam logic [7:0]  PKTFMT_MASK  = 8'h07;
  localparam logic [7:0]  IRQ_MASK     = 8'h30;
  localparam int          BIT_INJECT   = 7;
  localparam int          BIT_TERM     = 4;
  localparam int          BIT_HALFB    = 3;
  localparam int          BIT_REFERENCE_BUFFER_PIN   = 2;
  localparam int          BIT_REFSEL   = 1;
  localparam int          BIT_ECHO     = 0;
  localparam int          BIT_PATTERN  = 2;
  localparam int          BIT_TRIM_ERR = 5;
  localparam int          BIT_MAP_ERR  = 4;
  localparam logic [1:0]  SIZE_16      = 2'h0;
  localparam logic [1:0]  SIZE_24      = 2'h1;

  // ----------------------------------------------------------------
  // Checksum engine
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_POLY     = 16'h755b;
  localparam logic [15:0] CRC_SEED     = 16'hffff;
  localparam logic [15:0] CRC_FAULT    = 16'h0001;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic [CHANNELS-1:0][23:0] ccr_chan24_t;
  typedef logic [CHANNELS-1:0][31:0] ccr_chan32_t;

  typedef struct packed {
    logic termination_en;
    logic half_bias_en;
    logic ref_buffer_powerdown;
    logic internal_ref_en;
  } ccr_analog_s;

  typedef struct packed {
    logic [15:0] csum;
    logic [7:0]  ctrl;
    logic [7:0]  pkt;
    logic [7:0]  sts;
    logic [7:0]  msk;
    logic [7:0]  rdata;
    logic [7:0]  scan_addr;
    logic [15:0] crc;
    logic        clk_ret;
    logic        trim_inj;
    ccr_chan24_t packets;
    logic        pkt_valid;
  } ccr_state_s;

endpackage : ccr_pkg

// ---- rtl/ccr_config_regs.sv ----
// Configuration register bank with map checksum monitor and packet format.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Checksum polynomial 0x755B style, seed all ones; both sides agree.
// - Fault inject bit during conversions corrupts trim and map checksums.
// - Control bit 4, reset one, enables input pair termination.
// - Control bit 3 selects half-bias drive on output pairs.
// - Control bit 2 powers down the internal reference buffer.
// - Control bit 1: zero internal reference, one external reference.
// - Control bit 0, reset one, echoes serial clock onto return clock.
// - Pattern enable replaces packets with upper pattern register bits.
// - Size code 00 gives 16-bit, 01 gives 24-bit; reset 01.
// - Packets follow size, oversampling and pattern settings.
module ccr_config_regs
  import ccr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic                   irq,
  output logic      [ADDR_W-1:0] map_byte_addr,
  input  wire logic [DATA_W-1:0] map_byte_in,
  input  wire logic              conversion_active,
  input  wire logic              trim_checksum_error,
  output logic                   trim_fault_inject,
  output ccr_analog_s            analog,
  input  wire logic              serial_clock_in,
  output logic                   serial_clock_return,
  input  wire logic              oversample_active,
  input  wire logic              sample_valid,
  input  wire ccr_chan24_t       chan_sample,
  input  wire ccr_chan32_t       chan_pattern_value,
  output ccr_chan24_t            packet_word,
  output logic                   packet_valid
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Advances the checksum by one byte, most significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb)
      begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction : crc_byte

  // Tells whether a packet size code is one of the two legal ones.
  function automatic logic size_ok(input logic [1:0] s);
    return (s == SIZE_16) || (s == SIZE_24);
  endfunction : size_ok

  // ----------------------------------------------------------------
  // Packet formatting
  // ----------------------------------------------------------------

  ccr_state_s  st;
  ccr_state_s  next_st;
  ccr_chan24_t fmt;
  logic        pat_on;
  logic        size16;

  assign pat_on = st.pkt[BIT_PATTERN];
  assign size16 = (st.pkt[1:0] == SIZE_16);

  // Each channel picks pattern or sample, then trims to the packet size.
  for (genvar g = 0; g < CHANNELS; g++)
  begin : g_fmt
    logic [23:0] src;
    always_comb
    begin
      if (pat_on)
      begin
        src = chan_pattern_value[g][31:8];
      end
      else if (oversample_active)
      begin
        src = chan_sample[g];
      end
      else
      begin
        src = {chan_sample[g][15:0], 8'h00};
      end
    end
    // Short packets keep the upper sixteen bits and clear the low byte.
    assign fmt[g] = size16 ? {src[23:8], 8'h00} : src;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  logic [7:0]  scan_byte;
  logic [15:0] crc_now;
  logic [15:0] crc_final;
  logic        scan_end;
  logic        inject;
  logic        mismatch;

  assign inject    = st.ctrl[BIT_INJECT] & conversion_active;
  assign scan_end  = (st.scan_addr == SCAN_LAST);
  assign crc_now   = crc_byte(st.crc, scan_byte);
  assign crc_final = inject ? (crc_now ^ CRC_FAULT) : crc_now;
  assign mismatch  = scan_end && (crc_final != st.csum);

  // Own registers feed the scan directly; the rest comes from outside.
  always_comb
  begin
    unique case (st.scan_addr)
      ADDR_DEVCTL: scan_byte = st.ctrl;
      ADDR_PKTFMT: scan_byte = st.pkt;
      default:     scan_byte = map_byte_in;
    endcase
  end

  always_comb
  begin
    next_st = st;
    // Checksum walk from the top of the covered range downwards.
    if (scan_end)
    begin
      next_st.scan_addr = SCAN_FIRST;
      next_st.crc       = CRC_SEED;
    end
    else
    begin
      next_st.scan_addr = st.scan_addr - 8'h01;
      next_st.crc       = crc_now;
    end
    // Register writes; reserved bits and illegal sizes are dropped.
    if (wr)
    begin
      unique case (addr)
        ADDR_CSUM_LO: next_st.csum[7:0]  = wdata;
        ADDR_CSUM_HI: next_st.csum[15:8] = wdata;
        ADDR_DEVCTL:  next_st.ctrl = wdata & DEVCTL_MASK;
        ADDR_PKTFMT:
        begin
          next_st.pkt[BIT_PATTERN] = wdata[BIT_PATTERN];
          if (size_ok(wdata[1:0]))
          begin
            next_st.pkt[1:0] = wdata[1:0];
          end
        end
        ADDR_IRQ_STS: next_st.sts = st.sts & ~(wdata & IRQ_MASK);
        ADDR_IRQ_MSK: next_st.msk = wdata & IRQ_MASK;
        default:      next_st.sts = st.sts;
      endcase
    end
    // Sticky error events; a set beats a clear in the same cycle.
    if (mismatch)
    begin
      next_st.sts[BIT_MAP_ERR] = 1'b1;
    end
    if (trim_checksum_error)
    begin
      next_st.sts[BIT_TRIM_ERR] = 1'b1;
    end
    // Read data stands in the cycle after the strobe only.
    next_st.rdata = 8'h00;
    if (rd)
    begin
      unique case (addr)
        ADDR_CSUM_LO: next_st.rdata = st.csum[7:0];
        ADDR_CSUM_HI: next_st.rdata = st.csum[15:8];
        ADDR_DEVCTL:  next_st.rdata = st.ctrl & DEVCTL_MASK;
        ADDR_PKTFMT:  next_st.rdata = st.pkt & PKTFMT_MASK;
        ADDR_IRQ_STS: next_st.rdata = st.sts;
        ADDR_IRQ_MSK: next_st.rdata = st.msk;
        default:      next_st.rdata = 8'h00;
      endcase
    end
    next_st.trim_inj  = inject;
    next_st.clk_ret   = st.ctrl[BIT_ECHO] & serial_clock_in;
    next_st.pkt_valid = sample_valid;
    if (sample_valid)
    begin
      next_st.packets = fmt;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st           <= '0;
      st.csum      <= CSUM_RST;
      st.ctrl      <= DEVCTL_RST;
      st.pkt       <= PKTFMT_RST;
      st.scan_addr <= SCAN_FIRST;
      st.crc       <= CRC_SEED;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  assign rdata                       = st.rdata;
  assign irq                         = |(st.sts & st.msk);
  assign map_byte_addr               = st.scan_addr;
  assign trim_fault_inject           = st.trim_inj;
  assign analog.termination_en       = st.ctrl[BIT_TERM];
  assign analog.half_bias_en         = st.ctrl[BIT_HALFB];
  assign analog.ref_buffer_powerdown = st.ctrl[BIT_REFERENCE_BUFFER_PIN];
  assign analog.internal_ref_en      = ~st.ctrl[BIT_REFSEL];
  assign serial_clock_return         = st.clk_ret;
  assign packet_word                 = st.packets;
  assign packet_valid                = st.pkt_valid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MAP_CRC_MATCH: assert property (
    scan_end && !inject && crc_now == st.csum && !st.sts[BIT_MAP_ERR]
    && !(wr && addr == ADDR_IRQ_STS) |=> !st.sts[BIT_MAP_ERR])
    else $error("Map error set although checksum matched.");
  AST_INJECT_FLAGS: assert property (
    scan_end && inject && crc_now == st.csum |=> st.sts[BIT_MAP_ERR])
    else $error("Injected fault did not raise the map error.");
  AST_INJECT_TRIM: assert property (
    st.ctrl[BIT_INJECT] && conversion_active |=> trim_fault_inject)
    else $error("Trim fault inject not driven.");
  AST_TERM_WRITE: assert property (
    wr && addr == ADDR_DEVCTL |=>
      analog.termination_en == $past(wdata[BIT_TERM]))
    else $error("Termination enable does not follow the write.");
  AST_HALF_BIAS: assert property (
    wr && addr == ADDR_DEVCTL |=>
      analog.half_bias_en == $past(wdata[BIT_HALFB]))
    else $error("Half bias does not follow the write.");
  AST_REF_BUFFER_POWERDOWN: assert property (
    wr && addr == ADDR_DEVCTL |=>
      analog.ref_buffer_powerdown == $past(wdata[BIT_REFERENCE_BUFFER_PIN]))
    else $error("Buffer power down does not follow the write.");
  AST_REF_SEL: assert property (
    wr && addr == ADDR_DEVCTL |=>
      analog.internal_ref_en != $past(wdata[BIT_REFSEL]))
    else $error("Reference select inverted wrongly.");
  AST_ECHO: assert property (
    st.ctrl[BIT_ECHO] ##1 st.ctrl[BIT_ECHO] |->
      serial_clock_return == $past(serial_clock_in))
    else $error("Return clock does not echo the serial clock.");
  AST_PATTERN: assert property (
    sample_valid && pat_on && !size16 |=>
      packet_word[0] == $past(chan_pattern_value[0][31:8]))
    else $error("Pattern packet does not carry the pattern bits.");
  AST_SIZE_RSVD: assert property (
    wr && addr == ADDR_PKTFMT && !size_ok(wdata[1:0]) |=>
      $stable(st.pkt[1:0]))
    else $error("Reserved packet size accepted.");
  AST_SIZE16: assert property (
    sample_valid && size16 |=> packet_valid && packet_word[3][7:0] == 8'h00)
    else $error("Short packet not trimmed.");
  AST_RSVD_ZERO: assert property (
    rd && addr == ADDR_PKTFMT |=> rdata[7:3] == 5'h00)
    else $error("Reserved packet bits read nonzero.");

  COV_MAP_ERR: cover property (mismatch ##1 irq);
  COV_PATTERN: cover property (sample_valid && pat_on);
  COV_CLEAR: cover property (wr && addr == ADDR_IRQ_STS && |st.sts);

endmodule : ccr_config_regs
`default_nettype wire

// ---- tb/ccr_map_model.sv ----
// Far side model: outside register map bytes and the trim checksum engine.
`timescale 1ns/1ps
`default_nettype none
module ccr_map_model
  import ccr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] map_byte_addr,
  output logic      [DATA_W-1:0] map_byte_in,
  input  wire logic              trim_fault_inject,
  output logic                   trim_checksum_error
);
  // Map bytes are a fixed function of the address, answered in the same cycle.
  assign map_byte_in = map_byte_addr ^ 8'ha5;

  // The trim engine flags an error one cycle after a bit error is injected.
  always_ff @(posedge clk)
  begin
    if (rst)
      trim_checksum_error <= 1'b0;
    else
      trim_checksum_error <= trim_fault_inject;
  end
endmodule : ccr_map_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ccr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PASS = 149;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        conv = 1'b0;
  logic        sci = 1'b0;
  logic        os = 1'b0;
  logic        sv = 1'b0;
  ccr_chan24_t samp = '0;
  ccr_chan32_t pat = '0;
  logic [7:0]  rdata, mba, mbi, seed;
  logic        irq, trim_err, trim_inj, sco, pv;
  ccr_analog_s analog;
  ccr_chan24_t pw;
  logic [7:0]  rdq [$];
  ccr_chan24_t pq [$];
  logic [7:0]  fmts [4] = '{8'h01, 8'h00, 8'h05, 8'h04};
  logic [7:0]  ctls [4] = '{8'hff, 8'h0a, 8'h04, 8'h11};
  logic [15:0] crc;
  int          num_errors = 0;
  int          total_checks = 0;

  ccr_config_regs i_ccr_config_regs (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .map_byte_addr(mba), .map_byte_in(mbi), .conversion_active(conv),
    .trim_checksum_error(trim_err), .trim_fault_inject(trim_inj),
    .analog(analog), .serial_clock_in(sci), .serial_clock_return(sco),
    .oversample_active(os), .sample_valid(sv), .chan_sample(samp),
    .chan_pattern_value(pat), .packet_word(pw), .packet_valid(pv));

  ccr_map_model i_ccr_map_model (.clk(clk), .rst(rst), .map_byte_addr(mba),
    .map_byte_in(mbi), .trim_fault_inject(trim_inj),
    .trim_checksum_error(trim_err));

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next value of the stimulus shift register.
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], ^(seed & 8'hb8)};
    return seed;
  endfunction : rnd

  // Map checksum over 0xb9 down to 0x25, most significant bit first.
  function automatic logic [15:0] map_crc(input logic [7:0] ctl, pkf);
    logic [15:0] c;
    logic [7:0]  b;
    c = 16'hffff;
    for (int a = 8'hb9; a >= 8'h25; a--)
    begin
      b = (a == 8'h25) ? ctl : (a == 8'h26) ? pkf : 8'(a) ^ 8'ha5;
      for (int i = 7; i >= 0; i--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h755b : 16'h0000);
    end
    return c;
  endfunction : map_crc

  task automatic check(input logic [191:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rdq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // Sends one random sample set and notes the packets it must produce.
  task automatic send_pkt(input logic [7:0] fmt, input logic osm);
    ccr_chan24_t s;
    ccr_chan32_t p;
    ccr_chan24_t e;
    for (int c = 0; c < CHANNELS; c++)
    begin
      s[c] = {rnd(), rnd(), rnd()};
      p[c] = {rnd(), rnd(), rnd(), rnd()};
      e[c] = fmt[2] ? p[c][31:8] : osm ? s[c] : {s[c][15:0], 8'h00};
      if (fmt[1:0] == 2'h0)
        e[c][7:0] = 8'h00;
    end
    pq.push_back(e);
    @(posedge clk);
    os <= osm;
    samp <= s;
    pat <= p;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
  endtask : send_pkt

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Compares read data and packets against the oldest notes.
  always @(posedge clk)
  begin
    if (rd_d)
      check(rdata, rdq.pop_front());
    if (pv)
      check(pw, pq.pop_front());
    rd_d <= rd;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] b;
    seed = 8'd48;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(mba, 8'hb9);
    rd_reg(ADDR_DEVCTL, 8'h11);
    rd_reg(ADDR_PKTFMT, 8'h01);
    rd_reg(ADDR_CSUM_HI, 8'h00);
    rd_reg(8'h80, 8'h00);
    check(analog, 4'b1001);
    done("reset");
    foreach (ctls[i])
    begin
      wr_reg(ADDR_DEVCTL, ctls[i]);
      rd_reg(ADDR_DEVCTL, ctls[i] & 8'h9f);
      check(analog, {ctls[i][4:2], ~ctls[i][1]});
      repeat (3)
      begin
        b = rnd();
        @(posedge clk);
        sci <= b[0];
        @(posedge clk);
        #1 check(sco, ctls[i][0] & sci);
      end
    end
    done("control");
    foreach (fmts[i])
    begin
      wr_reg(ADDR_PKTFMT, fmts[i]);
      send_pkt(fmts[i], 1'b0);
      send_pkt(fmts[i], 1'b1);
    end
    wr_reg(ADDR_PKTFMT, 8'hfa);
    rd_reg(ADDR_PKTFMT, 8'h00);
    send_pkt(8'h00, 1'b0);
    done("packet");
    wr_reg(ADDR_DEVCTL, 8'h91);
    crc = map_crc(8'h91, 8'h00);
    wr_reg(ADDR_CSUM_LO, crc[7:0]);
    wr_reg(ADDR_CSUM_HI, crc[15:8]);
    rd_reg(ADDR_CSUM_LO, crc[7:0]);
    wr_reg(ADDR_IRQ_MSK, 8'h30);
    repeat (2 * PASS + 8) @(posedge clk);
    wr_reg(ADDR_IRQ_STS, 8'h30);
    repeat (PASS + 8) @(posedge clk);
    rd_reg(ADDR_IRQ_STS, 8'h00);
    check(irq, 1'b0);
    @(posedge clk);
    conv <= 1'b1;
    repeat (PASS + 8) @(posedge clk);
    rd_reg(ADDR_IRQ_STS, 8'h30);
    check(irq, 1'b1);
    check(trim_inj, 1'b1);
    @(posedge clk);
    conv <= 1'b0;
    wr_reg(ADDR_CSUM_LO, crc[7:0] ^ 8'h01);
    wr_reg(ADDR_IRQ_MSK, 8'h10);
    repeat (2 * PASS + 8) @(posedge clk);
    wr_reg(ADDR_IRQ_STS, 8'h30);
    repeat (PASS + 8) @(posedge clk);
    rd_reg(ADDR_IRQ_STS, 8'h10);
    check(irq, 1'b1);
    wr_reg(ADDR_IRQ_MSK, 8'h20);
    @(posedge clk);
    check(irq, 1'b0);
    done("checksum");
    repeat (4) @(posedge clk);
    check(pq.size(), 0);
    check(rdq.size(), 0);
    close_out();
  end

  // Watchdog set well beyond the roughly 1200 cycles the tests need.
  initial
  begin
    #(8000 * 50);
    num_errors++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
